// [design/psc_defines.svh]
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSC_OFF_STBY 8'h00
`define PSC_OFF_FUNC 8'h04
`define PSC_OFF_PORT 8'h08
`define PSC_OFF_DIR 8'h0c
`define PSC_OFF_ISEL 8'h10
`define PSC_OFF_IEN 8'h14
`define PSC_OFF_INDIS 8'h18
`define PSC_OFF_STAT 8'h1c
`define PSC_OFF_PINS 8'h20

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define PSC_LVL_BIT 0
`define PSC_REQ_LSB 1
`define PSC_REQ_MSB 2
`define PSC_REQ_SLEEP 2'h1
`define PSC_REQ_STBY 2'h2
`define PSC_ST_POST_BIT 0
`define PSC_ST_SLEEP_BIT 1
`define PSC_ST_STBY_BIT 2
`define PSC_ST_RUN_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PSC_RST_CFG 32'h0000_0000
`define PSC_RST_LVL 1'b0
`define PSC_RST_RDATA 32'h0000_0000

`endif

// [design/psc_pkg.sv]
package psc_pkg;

    // Operating state of the chip as seen by the pins
    typedef enum logic [2:0] {
        PSC_INIT,
        PSC_POST,
        PSC_RUN,
        PSC_SLEEP,
        PSC_STBY
    } psc_mode_e;

    // Per-pin software configuration
    typedef struct packed {
        logic func_sel;
        logic port_out;
        logic port_dir;
        logic irq_sel;
        logic irq_en;
        logic in_dis;
    } psc_pin_cfg_s;

    // Output drive of one pin
    typedef struct packed {
        logic out;
        logic oe;
    } psc_drv_s;

    // Registered pin state
    typedef struct packed {
        logic out;
        logic oe;
        logic core_in;
    } psc_pad_s;

endpackage : psc_pkg

// [design/psc_mode_ctl.sv]
`timescale 1ns/10ps
module psc_mode_ctl (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Mode events
    input wire logic init_n_i,
    input wire logic sleep_req_i,
    input wire logic stby_req_i,
    input wire logic wake_i,
    input wire logic cfg_wr_i,
    // Mode state
    output psc_pkg::psc_mode_e mode_o,
    output psc_pkg::psc_mode_e mode_next_o
);
    import psc_pkg::*;

    // ----------------------------------------
    // Mode state machine
    // ----------------------------------------
    psc_mode_e mode_reg; // Current mode
    psc_mode_e mode_next; // Next mode

    // Next mode; the init pin overrides every other event
    always_comb begin
        mode_next = mode_reg;
        if (!init_n_i) begin
            mode_next = PSC_INIT;
        end else begin
            case (mode_reg)
                PSC_INIT: begin
                    mode_next = PSC_POST;
                end
                PSC_POST, PSC_RUN: begin
                    // Post-init state stands until a configuration write or a sleep or standby request
                    if (stby_req_i) begin
                        mode_next = PSC_STBY;
                    end else if (sleep_req_i) begin
                        mode_next = PSC_SLEEP;
                    end else if (cfg_wr_i) begin
                        mode_next = PSC_RUN;
                    end
                end
                PSC_SLEEP, PSC_STBY: begin
                    if (wake_i) begin
                        mode_next = PSC_RUN;
                    end
                end
                default: begin
                    mode_next = PSC_INIT;
                end
            endcase
        end
    end

    // Register the mode
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_reg <= PSC_INIT;
        end else if (ce_i) begin
            mode_reg <= mode_next;
        end
    end

    assign mode_o = mode_reg;
    // Frozen clock enable means no mode change is seen
    assign mode_next_o = ce_i ? mode_next : mode_reg;

endmodule : psc_mode_ctl

// [design/psc_pin_cell.sv]
`timescale 1ns/10ps
module psc_pin_cell #(
    parameter bit IS_IRQ = 1'b0,
    parameter bit IS_ANALOG = 1'b0,
    parameter bit IS_FIX0 = 1'b0
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Mode and configuration
    input psc_pkg::psc_mode_e mode_i,
    input psc_pkg::psc_mode_e mode_next_i,
    input wire logic lvl_i,
    input psc_pkg::psc_pin_cfg_s cfg_i,
    // Peripheral side
    input psc_pkg::psc_drv_s periph_i,
    input wire logic periph_run_i,
    // Pin side
    input wire logic pad_in_i,
    output psc_pkg::psc_pad_s pad_o
);
    import psc_pkg::*;

    // ----------------------------------------
    // Pin state decision
    // ----------------------------------------
    psc_drv_s hold_reg; // Drive captured on entering a low-power mode
    psc_drv_s hold_next;
    psc_pad_s pad_reg; // What the pin does now
    psc_pad_s pad_next;
    psc_drv_s live_drv; // Normal-run drive
    psc_drv_s keep_drv; // Drive while holding
    logic live_in; // Normal-run input gate
    logic entering; // Last cycle before sleep or standby

    // Decided from the next mode so pins move on the mode's own edge
    always_comb begin
        live_drv = cfg_i.func_sel ? periph_i : psc_drv_s'{out: cfg_i.port_out, oe: cfg_i.port_dir};
        live_in = cfg_i.in_dis ? 1'b0 : pad_in_i;
        entering = (mode_next_i == PSC_SLEEP || mode_next_i == PSC_STBY) && mode_i != mode_next_i;
        // Capture the value driven just before the mode began
        hold_next = entering ? psc_drv_s'{out: pad_reg.out, oe: pad_reg.oe} : hold_reg;
        // A running peripheral keeps control, a port keeps its value
        keep_drv = (cfg_i.func_sel && periph_run_i) ? periph_i : hold_next;
        pad_next = '0; // Hi-Z, input tied low by default
        case (mode_next_i)
            PSC_INIT: begin
                pad_next = '0;
            end
            PSC_POST: begin
                // Analog and tied pins keep their input blocked
                pad_next.core_in = (IS_ANALOG || IS_FIX0) ? 1'b0 : pad_in_i;
            end
            PSC_RUN: begin
                pad_next = '{out: live_drv.out, oe: live_drv.oe, core_in: live_in};
            end
            PSC_SLEEP: begin
                pad_next = '{out: keep_drv.out, oe: keep_drv.oe, core_in: live_in};
            end
            PSC_STBY: begin
                if (lvl_i) begin
                    // Only an enabled interrupt input stays open
                    pad_next.core_in = (IS_IRQ && cfg_i.irq_sel && cfg_i.irq_en) ? pad_in_i : 1'b0;
                end else begin
                    pad_next = '{out: keep_drv.out, oe: keep_drv.oe, core_in: live_in};
                end
            end
            default: begin
                pad_next = '0;
            end
        endcase
    end

    // Register hold value and pin state
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_reg <= '0;
            pad_reg <= '0;
        end else if (ce_i) begin
            hold_reg <= hold_next;
            pad_reg <= pad_next;
        end
    end

    assign pad_o = pad_reg;

endmodule : psc_pin_cell

// [design/psc_top.sv]
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
`include "psc_defines.svh"

// Functional notes
// - Init pin low: all pins high impedance
// - Post-init pin states apply on init release
// - High impedance means output driver off
// - Low-power hold keeps last driven value
// - Hold: running peripheral keeps driving pin
// - Hold: port pin keeps its output value
// - Fixed input feeds constant zero inward after init
// - Level bit: clear holds, set floats pins
// - Interrupt pins pass input only when enabled
// - Interrupt channel pins use that exception
// - Analog pins float, input off after init
// - Disabled input never reaches internal logic, except an enabled interrupt pin in floating standby
module psc_top #(
    parameter int NUM_PINS = 24,
    parameter logic [31:0] IRQ_MASK = 32'h00ff_00ff,
    parameter logic [31:0] ANALOG_MASK = 32'h00ff_0000,
    parameter logic [31:0] FIX0_MASK = 32'h0000_0000
) (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Chip mode events
    input wire logic init_n_i,
    input wire logic wake_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Peripheral side
    input wire logic [NUM_PINS-1:0] periph_out_i,
    input wire logic [NUM_PINS-1:0] periph_oe_i,
    input wire logic [NUM_PINS-1:0] periph_run_i,
    output logic [NUM_PINS-1:0] core_in_o,
    // Pin side
    input wire logic [NUM_PINS-1:0] pad_in_i,
    output logic [NUM_PINS-1:0] pad_out_o,
    output logic [NUM_PINS-1:0] pad_oe_o
);
    import psc_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    // Each register is one 32-bit word covering all pins
    if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
        $error("NUM_PINS must be 1 to 32");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Address match
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Zero-extend a pin vector to a bus word
    function automatic logic [31:0] widen(input logic [NUM_PINS-1:0] v);
        logic [31:0] w;
        w = '0;
        w[NUM_PINS-1:0] = v;
        widen = w;
    endfunction : widen

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic lvl_reg; // Standby level select
    logic lvl_next;
    logic [NUM_PINS-1:0] func_reg; // 1: pin owned by a peripheral
    logic [NUM_PINS-1:0] func_next;
    logic [NUM_PINS-1:0] port_reg; // Port output data
    logic [NUM_PINS-1:0] port_next;
    logic [NUM_PINS-1:0] dir_reg; // Port output enable
    logic [NUM_PINS-1:0] dir_next;
    logic [NUM_PINS-1:0] isel_reg; // Pin selected as interrupt input
    logic [NUM_PINS-1:0] isel_next;
    logic [NUM_PINS-1:0] ien_reg; // Interrupt request enabled
    logic [NUM_PINS-1:0] ien_next;
    logic [NUM_PINS-1:0] indis_reg; // Digital input disabled
    logic [NUM_PINS-1:0] indis_next;
    logic [31:0] rdata_reg; // Read data, valid one cycle
    logic [31:0] rdata_next;
    logic wr_stby; // Write to standby control
    logic sleep_req; // Sleep request pulse
    logic stby_req; // Standby request pulse
    logic cfg_wr; // Any write other than to standby control
    psc_mode_e mode_q; // Current mode
    psc_mode_e mode_nx; // Next mode

    // Decode writes; mode requests are one-cycle pulses
    always_comb begin
        wr_stby = reg_wr_i && hit(reg_addr_i, `PSC_OFF_STBY);
        sleep_req = wr_stby && reg_wdata_i[`PSC_REQ_MSB:`PSC_REQ_LSB] == `PSC_REQ_SLEEP;
        stby_req = wr_stby && reg_wdata_i[`PSC_REQ_MSB:`PSC_REQ_LSB] == `PSC_REQ_STBY;
        cfg_wr = reg_wr_i && !wr_stby;
    end

    // Next register values; the init period clears configuration
    always_comb begin
        lvl_next = lvl_reg;
        func_next = func_reg;
        port_next = port_reg;
        dir_next = dir_reg;
        isel_next = isel_reg;
        ien_next = ien_reg;
        indis_next = indis_reg;
        if (mode_nx == PSC_INIT) begin
            lvl_next = `PSC_RST_LVL;
            func_next = NUM_PINS'(`PSC_RST_CFG);
            port_next = NUM_PINS'(`PSC_RST_CFG);
            dir_next = NUM_PINS'(`PSC_RST_CFG);
            isel_next = NUM_PINS'(`PSC_RST_CFG);
            ien_next = NUM_PINS'(`PSC_RST_CFG);
            indis_next = NUM_PINS'(`PSC_RST_CFG);
        end else if (reg_wr_i) begin
            if (wr_stby) begin
                lvl_next = reg_wdata_i[`PSC_LVL_BIT];
            end
            if (hit(reg_addr_i, `PSC_OFF_FUNC)) begin
                func_next = reg_wdata_i[NUM_PINS-1:0];
            end
            if (hit(reg_addr_i, `PSC_OFF_PORT)) begin
                port_next = reg_wdata_i[NUM_PINS-1:0];
            end
            if (hit(reg_addr_i, `PSC_OFF_DIR)) begin
                dir_next = reg_wdata_i[NUM_PINS-1:0];
            end
            if (hit(reg_addr_i, `PSC_OFF_ISEL)) begin
                isel_next = reg_wdata_i[NUM_PINS-1:0];
            end
            if (hit(reg_addr_i, `PSC_OFF_IEN)) begin
                ien_next = reg_wdata_i[NUM_PINS-1:0];
            end
            if (hit(reg_addr_i, `PSC_OFF_INDIS)) begin
                indis_next = reg_wdata_i[NUM_PINS-1:0];
            end
        end
    end

    // Read mux; unmapped addresses and idle cycles read zero
    always_comb begin
        rdata_next = `PSC_RST_RDATA;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PSC_OFF_STBY: rdata_next[`PSC_LVL_BIT] = lvl_reg;
                `PSC_OFF_FUNC: rdata_next = widen(func_reg);
                `PSC_OFF_PORT: rdata_next = widen(port_reg);
                `PSC_OFF_DIR: rdata_next = widen(dir_reg);
                `PSC_OFF_ISEL: rdata_next = widen(isel_reg);
                `PSC_OFF_IEN: rdata_next = widen(ien_reg);
                `PSC_OFF_INDIS: rdata_next = widen(indis_reg);
                `PSC_OFF_STAT: begin
                    rdata_next[`PSC_ST_POST_BIT] = (mode_q == PSC_POST);
                    rdata_next[`PSC_ST_SLEEP_BIT] = (mode_q == PSC_SLEEP);
                    rdata_next[`PSC_ST_STBY_BIT] = (mode_q == PSC_STBY);
                    rdata_next[`PSC_ST_RUN_BIT] = (mode_q == PSC_RUN);
                end
                `PSC_OFF_PINS: rdata_next = widen(core_in_o);
                default: rdata_next = `PSC_RST_RDATA;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_reg <= `PSC_RST_LVL;
            func_reg <= NUM_PINS'(`PSC_RST_CFG);
            port_reg <= NUM_PINS'(`PSC_RST_CFG);
            dir_reg <= NUM_PINS'(`PSC_RST_CFG);
            isel_reg <= NUM_PINS'(`PSC_RST_CFG);
            ien_reg <= NUM_PINS'(`PSC_RST_CFG);
            indis_reg <= NUM_PINS'(`PSC_RST_CFG);
            rdata_reg <= `PSC_RST_RDATA;
        end else if (ce_i) begin
            lvl_reg <= lvl_next;
            func_reg <= func_next;
            port_reg <= port_next;
            dir_reg <= dir_next;
            isel_reg <= isel_next;
            ien_reg <= ien_next;
            indis_reg <= indis_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ----------------------------------------
    // Mode control
    // ----------------------------------------
    psc_mode_ctl u_mode (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .init_n_i(init_n_i),
        .sleep_req_i(sleep_req),
        .stby_req_i(stby_req),
        .wake_i(wake_i),
        .cfg_wr_i(cfg_wr),
        .mode_o(mode_q),
        .mode_next_o(mode_nx)
    );

    // ----------------------------------------
    // Pin cells
    // ----------------------------------------
    // Pin class is fixed at build time by the masks
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
        psc_pin_cfg_s cfg_w; // This pin's configuration
        psc_pad_s pad_w; // This pin's registered state
        assign cfg_w = '{func_sel: func_reg[g], port_out: port_reg[g], port_dir: dir_reg[g],
                         irq_sel: isel_reg[g], irq_en: ien_reg[g], in_dis: indis_reg[g]};
        psc_pin_cell #(
            .IS_IRQ(IRQ_MASK[g]),
            .IS_ANALOG(ANALOG_MASK[g]),
            .IS_FIX0(FIX0_MASK[g])
        ) u_cell (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .mode_i(mode_q),
            .mode_next_i(mode_nx),
            .lvl_i(lvl_next),
            .cfg_i(cfg_w),
            .periph_i('{out: periph_out_i[g], oe: periph_oe_i[g]}),
            .periph_run_i(periph_run_i[g]),
            .pad_in_i(pad_in_i[g]),
            .pad_o(pad_w)
        );
        assign pad_out_o[g] = pad_w.out;
        assign pad_oe_o[g] = pad_w.oe;
        assign core_in_o[g] = pad_w.core_in;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic [NUM_PINS-1:0] nodig_w; // Pins with no digital input after init
    logic [NUM_PINS-1:0] irq_pass_w; // Inputs an enabled interrupt may pass
    logic [NUM_PINS-1:0] follow_w; // Running peripheral drive
    logic [NUM_PINS-1:0] frun_w; // Pins owned by a running peripheral
    logic [NUM_PINS-1:0] portout_w; // Port-owned pin levels
    assign nodig_w = ANALOG_MASK[NUM_PINS-1:0] | FIX0_MASK[NUM_PINS-1:0];
    assign irq_pass_w = pad_in_i & IRQ_MASK[NUM_PINS-1:0] & isel_reg & ien_reg;
    assign frun_w = func_reg & periph_run_i;
    assign follow_w = periph_out_i & frun_w;
    assign portout_w = pad_out_o & ~func_reg;

    init_hiz_a: assert property ((ce_i && !init_n_i) |=> pad_oe_o == '0)
        else $error("pin driven during init period");
    post_entry_a: assert property ((ce_i && mode_q == PSC_INIT && init_n_i) |=> mode_q == PSC_POST)
        else $error("post-init state not entered on release");
    post_pins_a: assert property (mode_q == PSC_POST |-> pad_oe_o == '0 && (core_in_o & nodig_w) == '0)
        else $error("post-init pin state wrong");
    stby_hiz_a: assert property ((mode_q == PSC_STBY && lvl_reg) |-> pad_oe_o == '0)
        else $error("pin driven in floating standby");
    fix_zero_a: assert property ((mode_q == PSC_STBY && lvl_reg) |-> (core_in_o & ~IRQ_MASK[NUM_PINS-1:0]) == '0)
        else $error("internal input not tied low");
    irq_exc_a: assert property ((ce_i && mode_nx == PSC_STBY && lvl_next) |=> core_in_o == $past(irq_pass_w))
        else $error("interrupt input exception wrong");
    port_hold_a: assert property ((ce_i && mode_q == PSC_SLEEP && mode_nx == PSC_SLEEP && !reg_wr_i)
        |=> $stable(portout_w))
        else $error("port output moved while holding");
    periph_hold_a: assert property ((ce_i && mode_nx == PSC_SLEEP) |=> (pad_out_o & $past(frun_w)) == $past(follow_w))
        else $error("running peripheral not followed");
    // Every pin not owned by a running peripheral keeps its pre-entry drive
    hold_entry_a: assert property ((ce_i && mode_q == PSC_RUN && mode_nx == PSC_SLEEP)
        |=> (pad_out_o & ~$past(frun_w)) == ($past(pad_out_o) & ~$past(frun_w))
            && (pad_oe_o & ~$past(frun_w)) == ($past(pad_oe_o) & ~$past(frun_w)))
        else $error("drive changed on entering sleep");
    in_block_a: assert property ((ce_i && mode_nx == PSC_RUN) |=> (core_in_o & $past(indis_reg)) == '0)
        else $error("disabled input reached core");
    // Requests are only taken from post-init or run, so only those modes count
    same_edge_a: assert property ((ce_i && stby_req && lvl_next && init_n_i
        && (mode_q == PSC_POST || mode_q == PSC_RUN)) |=> mode_q == PSC_STBY && pad_oe_o == '0)
        else $error("pins lag the mode change");

    init_release_c: cover property (!init_n_i ##1 init_n_i ##1 mode_q == PSC_POST);
    sleep_entry_c: cover property (mode_q == PSC_RUN ##1 mode_q == PSC_SLEEP);
    stby_irq_c: cover property (mode_q == PSC_STBY && lvl_reg && core_in_o != '0);
    wake_c: cover property (mode_q == PSC_STBY ##1 mode_q == PSC_RUN);

endmodule : psc_top

// [tb/psc_board_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// Board circuit on the port pins
// ----------------------------------------
module psc_board_model #(
    parameter int NUM_PINS = 24
) (
    // Board pull levels
    input wire logic [NUM_PINS-1:0] board_lvl_i,
    // Device drive
    input wire logic [NUM_PINS-1:0] pad_out_i,
    input wire logic [NUM_PINS-1:0] pad_oe_i,
    // Level seen at the pin
    output logic [NUM_PINS-1:0] pad_in_o
);
    // A driven pin reads back its own level; a released pin goes to the
    // board pull, so a floating line never shows the last driven value
    always_comb begin
        pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_lvl_i);
    end
endmodule : psc_board_model

// [tb/testbench.sv]
`timescale 1ns/10ps
`include "psc_defines.svh"
module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int N = 24;
    localparam logic [31:0] IRQ_M = 32'h00ff_00ff; // Interrupt channel pins
    localparam logic [31:0] ANA_M = 32'h00ff_0000; // Analog shared pins
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic ce_i = 1'b1;
    logic init_n_i = 1'b0;
    logic wake_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [N-1:0] periph_out_i = 24'h000001;
    logic [N-1:0] periph_oe_i = 24'h000003;
    logic [N-1:0] periph_run_i = 24'h000001;
    logic [N-1:0] core_in_o;
    logic [N-1:0] pad_in_i;
    logic [N-1:0] pad_out_o;
    logic [N-1:0] pad_oe_o;
    logic [N-1:0] board_lvl = 24'hffffff; // Board pulls every pin high
    logic [31:0] rd_val;
    int n_fail = 0;
    int comparisons = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    psc_top #(.NUM_PINS(N), .IRQ_MASK(IRQ_M), .ANALOG_MASK(ANA_M), .FIX0_MASK(32'h0)) psc_top_inst (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .init_n_i(init_n_i), .wake_i(wake_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
        .periph_run_i(periph_run_i), .core_in_o(core_in_o), .pad_in_i(pad_in_i),
        .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o)
    );

    psc_board_model #(.NUM_PINS(N)) psc_board_model_inst (
        .board_lvl_i(board_lvl), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_in_o(pad_in_i)
    );

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // The strobe edge is the second one; checks land 1 ns after it
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(what, reg_rdata_o, exp);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    // Only driven pins have a meaningful output value
    task automatic pins(input string what, input logic [N-1:0] oe, input logic [N-1:0] out);
        chk({what, " oe"}, {8'h0, pad_oe_o}, {8'h0, oe});
        chk({what, " out"}, {8'h0, pad_out_o & pad_oe_o}, {8'h0, out});
    endtask : pins

    task automatic wake_up();
        @(posedge ref_clk_i);
        wake_i <= 1'b1;
        @(posedge ref_clk_i);
        wake_i <= 1'b0;
        #1;
    endtask : wake_up

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        tick(2);
        pins("init", 24'h0, 24'h0);
        chk("init core_in", {8'h0, core_in_o}, 32'h0);
        reg_wr(`PSC_OFF_DIR, 32'hff); // Ignored while init is low
        @(posedge ref_clk_i);
        init_n_i <= 1'b1;
        tick(2);
        pins("post", 24'h0, 24'h0);
        chk("post core_in", {8'h0, core_in_o}, ~ANA_M & 32'h00ff_ffff);
        rd_chk("post status", `PSC_OFF_STAT, 32'h1);
        rd_chk("post dir", `PSC_OFF_DIR, 32'h0);
        // Run: pins 0,1 peripheral, 2..5 port driven, pin 8 input off
        reg_wr(`PSC_OFF_FUNC, 32'h3);
        reg_wr(`PSC_OFF_PORT, 32'hf0);
        reg_wr(`PSC_OFF_DIR, 32'h3c);
        reg_wr(`PSC_OFF_INDIS, 32'h100);
        reg_wr(`PSC_OFF_ISEL, 32'h010101);
        reg_wr(`PSC_OFF_IEN, 32'h010003);
        tick(2);
        pins("run", 24'h3f, 24'h31);
        chk("run core_in", {8'h0, core_in_o}, 32'hfffef1);
        rd_chk("core_in reg", `PSC_OFF_PINS, 32'hfffef1);
        rd_chk("run status", `PSC_OFF_STAT, 32'h8);
        rd_chk("unmapped", 8'h40, 32'h0);
        // Clock enable low freezes the pins although the peripheral moves
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        periph_out_i <= 24'h000002;
        tick(2);
        pins("freeze", 24'h3f, 24'h31);
        @(posedge ref_clk_i);
        ce_i <= 1'b1;
        periph_out_i <= 24'h000001;
        tick(1);
        // Sleep: running peripheral follows, stopped one and ports hold
        reg_wr(`PSC_OFF_STBY, 32'h2);
        pins("sleep entry", 24'h3f, 24'h31);
        @(posedge ref_clk_i);
        periph_out_i <= 24'h000002;
        tick(1);
        pins("sleep", 24'h3f, 24'h30);
        rd_chk("sleep status", `PSC_OFF_STAT, 32'h2);
        wake_up();
        pins("wake", 24'h3f, 24'h32);
        // Standby with level clear: everything holds its entry value
        @(posedge ref_clk_i);
        periph_out_i <= 24'h000001;
        reg_wr(`PSC_OFF_STBY, 32'h4);
        @(posedge ref_clk_i);
        periph_out_i <= 24'h000000;
        periph_run_i <= 24'h000000;
        tick(1);
        pins("stby0", 24'h3f, 24'h31);
        rd_chk("stby0 ctrl", `PSC_OFF_STBY, 32'h0);
        rd_chk("stby0 status", `PSC_OFF_STAT, 32'h4);
        wake_up();
        // Standby with level set: floats, inputs 0 except enabled irq pins
        reg_wr(`PSC_OFF_STBY, 32'h5);
        pins("stby1", 24'h0, 24'h0);
        tick(2);
        chk("stby1 core_in", {8'h0, core_in_o}, 32'h010001);
        rd_chk("stby1 ctrl", `PSC_OFF_STBY, 32'h1);
        wake_up();
        // Init pulled low mid-run: float and clear configuration
        @(posedge ref_clk_i);
        init_n_i <= 1'b0;
        tick(2);
        pins("reinit", 24'h0, 24'h0);
        chk("reinit core_in", {8'h0, core_in_o}, 32'h0);
        @(posedge ref_clk_i);
        init_n_i <= 1'b1;
        tick(2);
        rd_chk("reinit port", `PSC_OFF_PORT, 32'h0);
        pins("repost", 24'h0, 24'h0);
        end_sim();
    end

    // Whole run is under a hundred cycles; this limit only catches a hang
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
endmodule : testbench
